/* core/rcss_top.sv */
// Clock source select, free-running counter and clock output of the real-time clock
//
// How it works
// - non-subclock/4 source: calendar off, 8-bit counter
// - run bit starts and stops the counter
// - seconds register reads counter value in counter mode, zero otherwise
// - overflow irq only when enable bit set
// - divided system clock out only active/sleep
// - subclock out in active through watch modes
// - bits 6..4 select output; port enable gates
// - code 1000 is subclock/4; 1001+ prohibited
// - reserved top bit always reads zero
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module rcss_top #(
   parameter int CNT_W = 8 // Free-running counter width
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Subclock pin, sampled on the system clock
   input wire logic sub_clk_in,
   // Power mode from the system controller
   input wire rcss_pkg::rcss_pmode_t pwr_mode,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Clock output pin and its enable
   output logic clk_out_q,
   output logic clk_out_en_q,
   // Calendar tick at subclock/4 while the calendar runs
   output logic cal_tick_q,
   // Interrupt level
   output logic irq_q
);
   import rcss_pkg::*;

   initial begin
      if (CNT_W != 8) $error("rcss_top counter must be 8 bits wide");
   end

   // Decode of a mapped register offset
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == RCSS_OFS_CSR) || (a == RCSS_OFS_CR1) || (a == RCSS_OFS_CR2) ||
                  (a == RCSS_OFS_SEC) || (a == RCSS_OFS_PMR) || (a == RCSS_OFS_IST) ||
                  (a == RCSS_OFS_ICL) || (a == RCSS_OFS_IEN);
   endfunction

   // Software registers
   logic [7:0] csr_q; // Clock source select, bit 7 never stored
   logic run_q; // Counter run control
   logic counter_overflow_irq_enable_q; // Overflow irq enable
   logic pmr_cko_q; // Clock output pin enable
   logic ist_q; // Sticky overflow status
   logic ien_q; // Interrupt enable
   logic [CNT_W-1:0] cnt_q; // Free-running counter

   // Bus slave state
   logic aw_have_q; // Write address captured
   logic [7:0] aw_addr_q; // Captured write address
   logic w_have_q; // Write data captured
   logic [7:0] w_data_q; // Captured low byte
   logic w_strb_q; // Low byte lane strobe
   logic wr_fire; // Write carried out this cycle
   logic [31:0] rd_mux; // Read data selected by address

   // Subclock sampling
   logic sub_s; // Synchronised subclock level
   logic sub_prev_q; // Previous synchronised level
   logic sub_rise; // Rising edge of the subclock
   logic [1:0] sub_div_q; // Subclock /4 prescaler
   logic sub_tick; // One pulse every four subclock rising edges

   // Free-running source
   logic [15:0] presc_q; // System clock prescaler
   logic free_mode; // Calendar disabled, counter mode
   logic cal_mode; // Calendar running on subclock/4
   logic free_tick; // Counting pulse in counter mode
   logic cnt_step; // Counter advances this cycle
   logic ovf; // Counter wraps this cycle
   logic ovf_set; // Overflow reaches the status bit

   // Clock output
   logic sys_div; // Selected divided system clock
   logic out_sub; // Output select picks the subclock
   logic sys_mode_ok; // Divided system clock allowed in this power mode
   logic sub_mode_ok; // Subclock allowed in this power mode

   // Subclock pin passes two flops before use
   rcss_sync2 u_sub_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(sub_clk_in),
      .sync_out(sub_s)
   );

   // Divided system clocks for the output pin
   rcss_clkdiv #(
      .DIV_BITS(5)
   ) u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .div_sel(csr_q[RCSS_CSR_OSEL_HI:RCSS_CSR_OSEL_LO]),
      .div_q(sys_div)
   );

   // Mode decode from the source field
   assign cal_mode = (csr_q[3:0] == RCSS_SRC_SUBDIV4);
   assign free_mode = !csr_q[3];
   assign sub_rise = sub_s && !sub_prev_q;
   assign sub_tick = sub_rise && (sub_div_q == 2'(RCSS_SUB_PRESC - 1));
   // Source codes 0..7 pick system clock /4, /16 ... /2^(2n+2)
   assign free_tick = &(presc_q | ~((16'h0004 << {csr_q[2:0], 1'b0}) - 16'h0001));
   assign cnt_step = free_mode && run_q && free_tick;
   assign ovf = cnt_step && (cnt_q == RCSS_CNT_MAX);
   assign ovf_set = ovf && counter_overflow_irq_enable_q;
   assign out_sub = csr_q[RCSS_CSR_OSUB];
   assign sys_mode_ok = (pwr_mode == RCSS_PM_ACTIVE) || (pwr_mode == RCSS_PM_SLEEP);
   assign sub_mode_ok = sys_mode_ok || (pwr_mode == RCSS_PM_SUBACTIVE) ||
                        (pwr_mode == RCSS_PM_SUBSLEEP) || (pwr_mode == RCSS_PM_WATCH);
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

   // Subclock edge history and /4 prescaler
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sub_prev_q <= 1'b0;
         sub_div_q <= 2'h0;
      end else begin
         sub_prev_q <= sub_s;
         if (sub_rise) sub_div_q <= sub_div_q + 2'h1;
      end
   end

   // Calendar tick only while the calendar is selected
   always_ff @(posedge clk_sys) begin
      if (!rst_n) cal_tick_q <= 1'b0;
      else cal_tick_q <= cal_mode && sub_tick;
   end

   // System clock prescaler for counter mode sources
   always_ff @(posedge clk_sys) begin
      if (!rst_n) presc_q <= 16'h0000;
      else presc_q <= presc_q + 16'h0001;
   end

   // Free-running counter, held when stopped or in calendar mode
   always_ff @(posedge clk_sys) begin
      if (!rst_n) cnt_q <= '0;
      else if (cnt_step) cnt_q <= cnt_q + 1'b1;
   end

   // Write address channel
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel, only the low byte lane is stored
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         w_have_q <= 1'b0;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata[7:0];
         w_strb_q <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response, error for an unmapped address
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RCSS_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_addr_q) ? RCSS_RESP_OKAY : RCSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers written from the bus
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         csr_q <= RCSS_CSR_RST;
         run_q <= RCSS_CR_RST[0];
         counter_overflow_irq_enable_q <= RCSS_CR_RST[0];
         pmr_cko_q <= RCSS_CR_RST[0];
         ien_q <= RCSS_CR_RST[0];
      end else if (wr_fire && w_strb_q) begin
         case (aw_addr_q)
            RCSS_OFS_CSR: csr_q <= {1'b0, w_data_q[6:0]};
            RCSS_OFS_CR1: run_q <= w_data_q[RCSS_CR1_RUN];
            RCSS_OFS_CR2: counter_overflow_irq_enable_q <= w_data_q[RCSS_CR2_COUNTER_OVERFLOW_IRQ_ENABLE];
            RCSS_OFS_PMR: pmr_cko_q <= w_data_q[RCSS_PMR_CKO];
            RCSS_OFS_IEN: ien_q <= w_data_q[RCSS_IRQ_OVF];
            default: begin
               // Read-only and clear registers store nothing here
            end
         endcase
      end
   end

   // Sticky overflow status, a new overflow wins over a clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) ist_q <= 1'b0;
      else if (ovf_set) ist_q <= 1'b1;
      else if (wr_fire && w_strb_q && (aw_addr_q == RCSS_OFS_ICL) && w_data_q[RCSS_IRQ_OVF])
         ist_q <= 1'b0;
   end

   // Interrupt level while an enabled status bit is set
   always_ff @(posedge clk_sys) begin
      if (!rst_n) irq_q <= 1'b0;
      else irq_q <= ist_q && ien_q;
   end

   // Read data selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         RCSS_OFS_CSR: rd_mux[7:0] = {1'b0, csr_q[6:0]};
         RCSS_OFS_CR1: rd_mux[RCSS_CR1_RUN] = run_q;
         RCSS_OFS_CR2: rd_mux[RCSS_CR2_COUNTER_OVERFLOW_IRQ_ENABLE] = counter_overflow_irq_enable_q;
         RCSS_OFS_SEC: rd_mux[CNT_W-1:0] = free_mode ? cnt_q : '0;
         RCSS_OFS_PMR: rd_mux[RCSS_PMR_CKO] = pmr_cko_q;
         RCSS_OFS_IST: rd_mux[RCSS_IRQ_OVF] = ist_q;
         RCSS_OFS_IEN: rd_mux[RCSS_IRQ_OVF] = ien_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read address and data channels
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RCSS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RCSS_RESP_OKAY : RCSS_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Clock output pin, gated by port enable and power mode
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clk_out_q <= 1'b0;
         clk_out_en_q <= 1'b0;
      end else begin
         clk_out_en_q <= pmr_cko_q;
         if (!pmr_cko_q) clk_out_q <= 1'b0;
         else if (out_sub) clk_out_q <= sub_mode_ok && sub_s;
         else clk_out_q <= sys_mode_ok && sys_div;
      end
   end

   // Checks on the block behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_count_step: assert property (cnt_step && (cnt_q != RCSS_CNT_MAX)
      |=> cnt_q == $past(cnt_q) + 8'h01) else $error("counter did not advance");
   a_cal_hold: assert property (!free_mode |=> $stable(cnt_q))
      else $error("counter moved in calendar mode");
   a_stop_hold: assert property (!run_q |=> $stable(cnt_q))
      else $error("stopped counter moved");
   a_sec_read: assert property ((s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == RCSS_OFS_SEC) && free_mode)
      |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(cnt_q)))
      else $error("seconds read lost counter value");
   a_ovf_gate: assert property ((!ist_q && !(ovf && counter_overflow_irq_enable_q)) |=> !ist_q)
      else $error("status set without enabled overflow");
   a_ovf_irq: assert property ((ovf && counter_overflow_irq_enable_q && ien_q) |=> ist_q ##1 irq_q)
      else $error("overflow interrupt missing");
   a_sys_gated: assert property ((!out_sub && !sys_mode_ok) |=> !clk_out_q)
      else $error("system clock out in wrong mode");
   a_sub_out: assert property ((pmr_cko_q && out_sub && sub_mode_ok)
      |=> clk_out_q == $past(sub_s)) else $error("subclock not on output");
   a_pin_off: assert property (!pmr_cko_q |=> !clk_out_q && !clk_out_en_q)
      else $error("output pin driven while disabled");
   a_code_cal: assert property ((csr_q[3:0] != RCSS_SRC_SUBDIV4) |=> !cal_tick_q)
      else $error("calendar tick outside code 1000");
   a_rsvd_zero: assert property ((s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == RCSS_OFS_CSR)) |=> !s_axi_rdata[RCSS_CSR_RSVD])
      else $error("reserved bit read as one");
endmodule

/* core/rcss_pkg.sv */
// Package with register map, field positions and reset values of the clock source select block
package rcss_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] RCSS_OFS_CSR = 8'h00; // Clock source select
   localparam logic [7:0] RCSS_OFS_CR1 = 8'h04; // Control one, run bit
   localparam logic [7:0] RCSS_OFS_CR2 = 8'h08; // Control two, overflow irq enable
   localparam logic [7:0] RCSS_OFS_SEC = 8'h0c; // Seconds data, counter value
   localparam logic [7:0] RCSS_OFS_PMR = 8'h10; // Port mode one, clock output enable
   localparam logic [7:0] RCSS_OFS_IST = 8'h14; // Interrupt status, read only
   localparam logic [7:0] RCSS_OFS_ICL = 8'h18; // Interrupt clear, write only
   localparam logic [7:0] RCSS_OFS_IEN = 8'h1c; // Interrupt enable
   // Field positions
   localparam int RCSS_CSR_RSVD = 7; // Reserved, reads zero
   localparam int RCSS_CSR_OSEL_HI = 6; // Output select top bit
   localparam int RCSS_CSR_OSEL_LO = 5; // Output select low divider bit
   localparam int RCSS_CSR_OSUB = 4; // Output subclock select
   localparam int RCSS_CR1_RUN = 0; // Run control bit
   localparam int RCSS_CR2_COUNTER_OVERFLOW_IRQ_ENABLE = 0; // Overflow irq enable bit
   localparam int RCSS_PMR_CKO = 0; // Clock output pin enable
   localparam int RCSS_IRQ_OVF = 0; // Overflow status bit
   // Reset values
   localparam logic [7:0] RCSS_CSR_RST = 8'h08; // Source code 1000 after reset
   localparam logic [7:0] RCSS_CR_RST = 8'h00; // Control registers clear
   // Codes
   localparam logic [3:0] RCSS_SRC_SUBDIV4 = 4'h8; // Subclock divided by four
   localparam int RCSS_SUB_PRESC = 4; // Subclock prescale for calendar tick
   localparam logic [7:0] RCSS_CNT_MAX = 8'hff; // Free-running counter top
   localparam logic [1:0] RCSS_RESP_OKAY = 2'h0; // AXI OKAY
   localparam logic [1:0] RCSS_RESP_SLVERR = 2'h2; // AXI SLVERR
   // Power modes seen by the block
   typedef enum logic [2:0] {
      RCSS_PM_ACTIVE,
      RCSS_PM_SLEEP,
      RCSS_PM_SUBACTIVE,
      RCSS_PM_SUBSLEEP,
      RCSS_PM_WATCH,
      RCSS_PM_STANDBY
   } rcss_pmode_t;
endpackage

/* core/rcss_sync2.sv */
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module rcss_sync2 (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q; // First stage, read only by the second
   // Two stages, cleared by reset
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* core/rcss_clkdiv.sv */
// System clock divider giving the divided clocks for the clock output pin
`timescale 1ns/10ps
module rcss_clkdiv #(
   parameter int DIV_BITS = 5 // Enough for the divide by 32 tap
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Selection of the divider tap, 0 gives /4 up to 3 giving /32
   input wire logic [1:0] div_sel,
   output logic div_q
);
   logic [DIV_BITS-1:0] cnt_q; // Free-running divider count
   initial begin
      if (DIV_BITS < 5) $error("rcss_clkdiv needs at least five bits");
   end
   // Divider counts every system clock
   always_ff @(posedge clk_sys) begin
      if (!rst_n) cnt_q <= '0;
      else cnt_q <= cnt_q + 1'b1;
   end
   // Tap n+1 of the count toggles at clock/(4*2^n); code 2 gives /16
   // The index is widened to three bits so code 3 reaches tap 4 and does not wrap to tap 0
   always_ff @(posedge clk_sys) begin
      if (!rst_n) div_q <= 1'b0;
      else div_q <= cnt_q[{1'b0, div_sel} + 3'd1];
   end
endmodule

/* sim/rcss_top_tb_top.sv */
// Self-checking testbench for the clock source select block
`timescale 1ns/10ps
module rcss_top_tb_top;
   import rcss_pkg::*;
   // Clock, reset and stimulus signals
   logic clk_sys, rst_n, sub_clk_in;
   rcss_pmode_t pwr_mode;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic clk_out_q, clk_out_en_q, cal_tick_q, irq_q;
   int err_count = 0; // Mismatches seen
   int n_compared = 0; // Comparisons made
   int sub_cnt = 0; // Subclock half-period counter
   // Device under test
   rcss_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sub_clk_in(sub_clk_in),
      .pwr_mode(pwr_mode), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .clk_out_q(clk_out_q), .clk_out_en_q(clk_out_en_q), .cal_tick_q(cal_tick_q),
      .irq_q(irq_q));
   // System clock, 100 ns period
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Subclock, toggled every seven system cycles so its period is 14 cycles
   always @(posedge clk_sys) begin
      sub_cnt <= (sub_cnt == 6) ? 0 : sub_cnt + 1;
      if (sub_cnt == 6) begin
         sub_clk_in <= ~sub_clk_in;
      end
   end
   // Verdict and end of run
   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Compare one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // Wait a number of clock edges
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // AXI4-Lite write; address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      // Wait for the answer however long it takes; only the watchdog ends a hang
      forever begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   // AXI4-Lite read; rready held until the data is taken
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      d = 32'h0;
      r = 2'h3;
      // Wait for the data however long it takes; only the watchdog ends a hang
      forever begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   // Write a mapped register and expect OKAY
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      check({30'h0, r}, {30'h0, RCSS_RESP_OKAY}, "write response");
   endtask
   // Read a mapped register and compare it
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check(d, exp, msg);
      check({30'h0, r}, {30'h0, RCSS_RESP_OKAY}, "read response");
   endtask
   // Count clock output rises and calendar ticks over n cycles
   task automatic sample(input int n, output int rises, output int ticks);
      logic prev;
      rises = 0;
      ticks = 0;
      prev = clk_out_q;
      repeat (n) begin
         @(posedge clk_sys);
         if (clk_out_q === 1'b1 && prev === 1'b0) rises++;
         if (cal_tick_q === 1'b1) ticks++;
         prev = clk_out_q;
      end
   endtask
   // Reset values, reserved bit and unmapped address
   task automatic test_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(RCSS_OFS_CSR, {24'h0, RCSS_CSR_RST}, "select reset");
      wr(RCSS_OFS_CSR, 8'h88);
      rd_chk(RCSS_OFS_CSR, 32'h08, "reserved bit");
      rd_chk(RCSS_OFS_SEC, 32'h0, "seconds zero in calendar mode");
      axi_read(8'h20, d, r);
      check({30'h0, r}, {30'h0, RCSS_RESP_SLVERR}, "unmapped read");
      axi_write(8'h20, 8'h01, r);
      check({30'h0, r}, {30'h0, RCSS_RESP_SLVERR}, "unmapped write");
   endtask
   // Calendar ticks at subclock/4 only with code 1000
   task automatic test_calendar();
      int ri, ti;
      sample(560, ri, ti);
      check(32'(ti >= 8 && ti <= 12), 32'h1, "calendar tick rate");
      wr(RCSS_OFS_CSR, 8'h00);
      idle(10);
      sample(200, ri, ti);
      check(32'(ti), 32'h0, "no tick in counter mode");
   endtask
   // Free-running counter run control, readback and overflow interrupt
   task automatic test_counter();
      logic [31:0] a, b, c;
      logic [1:0] r;
      axi_read(RCSS_OFS_SEC, a, r);
      idle(20);
      axi_read(RCSS_OFS_SEC, b, r);
      check(b, a, "counter held while stopped");
      wr(RCSS_OFS_CR1, 8'h01);
      idle(40);
      wr(RCSS_OFS_CR1, 8'h00);
      axi_read(RCSS_OFS_SEC, c, r);
      check(32'(c != a && c[31:8] == 24'h0), 32'h1, "counter advanced");
      wr(RCSS_OFS_IEN, 8'h01);
      wr(RCSS_OFS_CR1, 8'h01);
      idle(1100);
      rd_chk(RCSS_OFS_IST, 32'h0, "no status with enable off");
      check({31'h0, irq_q}, 32'h0, "no irq with enable off");
      wr(RCSS_OFS_CR2, 8'h01);
      idle(1100);
      wr(RCSS_OFS_CR1, 8'h00);
      rd_chk(RCSS_OFS_IST, 32'h1, "overflow status");
      check({31'h0, irq_q}, 32'h1, "overflow irq");
      wr(RCSS_OFS_IEN, 8'h00);
      idle(2);
      check({31'h0, irq_q}, 32'h0, "irq masked");
      wr(RCSS_OFS_ICL, 8'h01);
      rd_chk(RCSS_OFS_IST, 32'h0, "status cleared");
      wr(RCSS_OFS_IEN, 8'h01);
      idle(2);
      check({31'h0, irq_q}, 32'h0, "irq stays low");
   endtask
   // Clock output selection, power modes and pin enable
   task automatic test_clk_out();
      int i, ri, ti, dv;
      rcss_pmode_t m;
      wr(RCSS_OFS_PMR, 8'h01);
      for (i = 0; i < 4; i++) begin
         dv = 4 << i;
         wr(RCSS_OFS_CSR, {1'b0, 2'(i), 1'b0, 4'h8});
         idle(10);
         check({31'h0, clk_out_en_q}, 32'h1, "pin enabled");
         sample(320, ri, ti);
         check(32'(ri >= 320 / dv - 1 && ri <= 320 / dv + 1), 32'h1, "divided rate");
      end
      wr(RCSS_OFS_CSR, 8'h08);
      pwr_mode <= RCSS_PM_SUBACTIVE;
      idle(10);
      sample(100, ri, ti);
      check(32'(ri), 32'h0, "divided out stopped");
      pwr_mode <= RCSS_PM_SLEEP;
      idle(10);
      sample(100, ri, ti);
      check(32'(ri >= 24 && ri <= 26), 32'h1, "divided out in sleep");
      wr(RCSS_OFS_CSR, 8'h18);
      for (i = 0; i < 6; i++) begin
         m = rcss_pmode_t'(i);
         pwr_mode <= m;
         idle(10);
         sample(140, ri, ti);
         check(32'(ri >= 8 && ri <= 12), 32'(i < 5), "subclock out");
      end
      pwr_mode <= RCSS_PM_ACTIVE;
      wr(RCSS_OFS_PMR, 8'h00);
      idle(10);
      sample(100, ri, ti);
      check({31'h0, clk_out_en_q}, 32'h0, "pin disabled");
      check(32'(ri), 32'h0, "pin quiet");
   endtask
   // Watchdog against a hung handshake
   initial begin
      idle(60000);
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      sub_clk_in = 1'b0;
      pwr_mode = RCSS_PM_ACTIVE;
      s_axi_awvalid = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_wvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_rready = 1'b0;
      idle(3);
      rst_n <= 1'b1;
      idle(2);
      test_regs();
      test_clk_out();
      test_calendar();
      test_counter();
      complete_run();
   end
endmodule
